// File: frame_stats_regs.sv
// Behaviour
// - Clearing mask-control top bit selects a stored mask word for the readback pair.
// - Readback bit one means that byte of each 192-byte group is masked.
// - Sixteen-bit loss-of-frame counter counts each lock-to-unlock transition.
// - Lock is dropped only after four consecutive bad framing patterns.
// - Sixteen-bit pattern error counter counts bad patterns seen while in frame.
// - A single bad pattern counts an error but keeps lock.
// - Read-only sixteen-bit design identity, meaningful in upper byte only.
// - Write ROM address to version port, read back the character there.
// - Version string is up to 64 bytes; six address bits used.
// - Version string holds names, version, date and DMA channel counts.
// - Hold control freezes both framing counters; cleared, they run.
// - Mask-control top bit one writes the mask word, zero selects read.
//
// The APB slave port was chosen for this implementation.
module frame_stats_regs
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic      [31:0] o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_pat_valid,
  input  wire logic        i_pat_good,
  output logic             o_frame_lock,
  output logic [191:0]     o_demux_mask,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  frame_stats_pkg::pattern_s pat;
  logic        setup;
  logic        wr_en;
  logic [9:0]  word_idx;
  logic [7:0]  wbyte;

  assign pat      = {i_pat_valid, i_pat_good};
  // No wait state: data is registered at the setup cycle
  assign setup    = i_psel && !i_penable;
  assign wr_en    = i_psel && i_penable && o_pready && i_pwrite;
  assign word_idx = i_paddr[11:2];
  assign wbyte    = i_pwdata[7:0];

  function automatic logic hit(input logic [9:0] idx, input int unsigned off);
    hit = (idx == 10'(off));
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    mapped = hit(idx, frame_stats_pkg::IDX_IDENT_LO) || hit(idx, frame_stats_pkg::IDX_IDENT_HI)
          || hit(idx, frame_stats_pkg::IDX_VERSION)
          || (idx >= 10'(frame_stats_pkg::IDX_MASK_LO) && idx <= 10'(frame_stats_pkg::IDX_IRQ_MASK));
  endfunction

  // One write strobe per register keeps each register's process to itself
  logic        wr_ctrl;
  logic        wr_mask_lo;
  logic        wr_mask_hi;
  logic        wr_mask_ctrl;
  logic        wr_version;
  logic        wr_irq_stat;
  logic        wr_irq_mask;

  assign wr_ctrl      = wr_en && hit(word_idx, frame_stats_pkg::IDX_CTRL);
  assign wr_mask_lo   = wr_en && hit(word_idx, frame_stats_pkg::IDX_MASK_LO);
  assign wr_mask_hi   = wr_en && hit(word_idx, frame_stats_pkg::IDX_MASK_HI);
  assign wr_mask_ctrl = wr_en && hit(word_idx, frame_stats_pkg::IDX_MASK_CTRL);
  assign wr_version   = wr_en && hit(word_idx, frame_stats_pkg::IDX_VERSION);
  assign wr_irq_stat  = wr_en && hit(word_idx, frame_stats_pkg::IDX_IRQ_STAT);
  assign wr_irq_mask  = wr_en && hit(word_idx, frame_stats_pkg::IDX_IRQ_MASK);

  // ----------------------------------------------------------------
  // Control and mask registers
  // ----------------------------------------------------------------
  logic        hold_r;
  logic [7:0]  mask_lo_r;
  logic [7:0]  mask_hi_r;
  logic [3:0]  mask_sel_r;
  logic [15:0] mask_mem [0:frame_stats_pkg::MASK_WORDS-1];
  logic [15:0] rdbk_r;
  logic [5:0]  ver_addr_r;
  logic [7:0]  ver_char;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      hold_r <= 1'b0;
    else if (i_ce && wr_ctrl)
      hold_r <= wbyte[frame_stats_pkg::CTRL_HOLD_BIT];
  end

  // Staged halves reach the array only when the control byte strobes them in
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      mask_lo_r <= 8'h00;
      mask_hi_r <= 8'h00;
    end
    else if (i_ce)
    begin
      if (wr_mask_lo)
        mask_lo_r <= wbyte;
      if (wr_mask_hi)
        mask_hi_r <= wbyte;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      mask_sel_r <= 4'h0;
    else if (i_ce && wr_mask_ctrl)
      mask_sel_r <= wbyte[3:0];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      ver_addr_r <= 6'h00;
    else if (i_ce && wr_version)
      ver_addr_r <= wbyte[frame_stats_pkg::VER_ADDR_BITS-1:0];
  end

  // Word 0 bit 15 is the first byte of the group, so words pack high-first
  generate
    for (genvar w = 0; w < frame_stats_pkg::MASK_WORDS; w++)
    begin : g_mask
      always_ff @(posedge i_core_clk)
      begin
        if (i_sys_rst)
          mask_mem[w] <= frame_stats_pkg::MASK_RESET;
        else if (i_ce && wr_mask_ctrl && wbyte[frame_stats_pkg::MASK_WRITE_BIT]
                 && wbyte[3:0] == 4'(w))
          mask_mem[w] <= {mask_hi_r, mask_lo_r};
      end
      always_ff @(posedge i_core_clk)
      begin
        if (i_sys_rst)
          o_demux_mask[191-16*w -: 16] <= frame_stats_pkg::MASK_RESET;
        else if (i_ce)
          o_demux_mask[191-16*w -: 16] <= mask_mem[w];
      end
    end
  endgenerate

  logic [3:0]  rdbk_sel;
  logic        rdbk_in_range;

  // Word numbers past the array read as zero rather than aliasing a real word
  assign rdbk_sel      = wbyte[3:0];
  assign rdbk_in_range = rdbk_sel < 4'(frame_stats_pkg::MASK_WORDS);

  // Readback follows the last read-select; a write-select leaves it alone
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      rdbk_r <= frame_stats_pkg::MASK_RESET;
    else if (i_ce && wr_mask_ctrl && !wbyte[frame_stats_pkg::MASK_WRITE_BIT])
      rdbk_r <= rdbk_in_range ? mask_mem[rdbk_sel] : 16'h0000;
  end

  version_rom u_rom
  (
    .i_core_clk (i_core_clk),
    .i_ce       (i_ce),
    .i_addr     (ver_addr_r),
    .o_char     (ver_char)
  );

  // ----------------------------------------------------------------
  // Frame alignment
  // ----------------------------------------------------------------
  frame_stats_pkg::sync_state_e state_r;
  logic [2:0]  bad_run_r;
  logic        bad_in_frame;
  logic        lose_lock;

  // Hunting ignores bad patterns, so only a locked channel can count errors
  assign bad_in_frame = pat.pat_valid && !pat.pat_good && state_r == frame_stats_pkg::SYNC_LOCKED;
  assign lose_lock    = bad_in_frame && bad_run_r == 3'(frame_stats_pkg::BAD_RUN_LIMIT - 1);

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state_r   <= frame_stats_pkg::SYNC_HUNT;
      bad_run_r <= 3'h0;
    end
    else if (i_ce && pat.pat_valid)
    begin
      case (state_r)
        frame_stats_pkg::SYNC_HUNT:
        begin
          bad_run_r <= 3'h0;
          if (pat.pat_good)
            state_r <= frame_stats_pkg::SYNC_LOCKED;
        end
        frame_stats_pkg::SYNC_LOCKED:
        begin
          if (pat.pat_good)
            bad_run_r <= 3'h0;
          else if (lose_lock)
          begin
            state_r   <= frame_stats_pkg::SYNC_HUNT;
            bad_run_r <= 3'h0;
          end
          else
            bad_run_r <= bad_run_r + 3'h1;
        end
        default:
          state_r <= frame_stats_pkg::SYNC_HUNT;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_frame_lock <= 1'b0;
    else if (i_ce)
      o_frame_lock <= (state_r == frame_stats_pkg::SYNC_LOCKED);
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic [15:0] lof_cnt_r;
  logic [15:0] pat_cnt_r;

  // Events arriving during hold are dropped, the price of a stable read
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      lof_cnt_r <= 16'h0000;
    else if (i_ce && !hold_r
             && lose_lock && lof_cnt_r != frame_stats_pkg::COUNT_MAX)
      lof_cnt_r <= lof_cnt_r + 16'h0001;
  end

  // Saturating keeps a long outage from reading back as a small count
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      pat_cnt_r <= 16'h0000;
    else if (i_ce && !hold_r
             && bad_in_frame && pat_cnt_r != frame_stats_pkg::COUNT_MAX)
      pat_cnt_r <= pat_cnt_r + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  always_comb
  begin
    irq_set                               = 2'b00;
    irq_set[frame_stats_pkg::IRQ_LOF_BIT] = lose_lock;
    irq_set[frame_stats_pkg::IRQ_PAT_BIT] = bad_in_frame;
  end

  assign irq_clr = wr_irq_stat ? wbyte[1:0] : 2'b00;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      irq_stat_r <= 2'b00;
    else if (i_ce)
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      irq_mask_r <= 2'b00;
    else if (i_ce && wr_irq_mask)
      irq_mask_r <= wbyte[1:0];
  end

  // One cycle behind the status so the pin never shows a decode glitch
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else if (i_ce)
      o_irq <= |(irq_stat_r & irq_mask_r);
  end

  // ----------------------------------------------------------------
  // Read mux and handshake
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = 8'h00;
    case (word_idx)
      10'(frame_stats_pkg::IDX_IDENT_LO):  rd_byte = frame_stats_pkg::DESIGN_IDENT[7:0];
      10'(frame_stats_pkg::IDX_IDENT_HI):  rd_byte = frame_stats_pkg::DESIGN_IDENT[15:8];
      10'(frame_stats_pkg::IDX_VERSION):   rd_byte = ver_char;
      10'(frame_stats_pkg::IDX_MASK_LO):   rd_byte = mask_lo_r;
      10'(frame_stats_pkg::IDX_MASK_HI):   rd_byte = mask_hi_r;
      10'(frame_stats_pkg::IDX_MASK_CTRL): rd_byte = {4'h0, mask_sel_r};
      10'(frame_stats_pkg::IDX_RDBK_LO):   rd_byte = rdbk_r[7:0];
      10'(frame_stats_pkg::IDX_RDBK_HI):   rd_byte = rdbk_r[15:8];
      10'(frame_stats_pkg::IDX_LOF_LO):    rd_byte = lof_cnt_r[7:0];
      10'(frame_stats_pkg::IDX_LOF_HI):    rd_byte = lof_cnt_r[15:8];
      10'(frame_stats_pkg::IDX_PAT_LO):    rd_byte = pat_cnt_r[7:0];
      10'(frame_stats_pkg::IDX_PAT_HI):    rd_byte = pat_cnt_r[15:8];
      10'(frame_stats_pkg::IDX_CTRL):      rd_byte = {6'h00, o_frame_lock, hold_r};
      10'(frame_stats_pkg::IDX_IRQ_STAT):  rd_byte = {6'h00, irq_stat_r};
      10'(frame_stats_pkg::IDX_IRQ_MASK):  rd_byte = {6'h00, irq_mask_r};
      default:                             rd_byte = 8'h00;
    endcase
  end

  // Registered answer is ready in the first access cycle and keeps every bus output on a flop
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else if (i_ce)
    begin
      o_pready  <= setup;
      o_pslverr <= setup && !mapped(word_idx);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_prdata <= 32'h0000_0000;
    else if (i_ce && setup)
      o_prdata <= {24'h000000, rd_byte};
  end

endmodule

// File: frame_stats_pkg.sv
package frame_stats_pkg;

  // ----------------------------------------------------------------
  // Register word indices (byte-wide registers, one per aligned word)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_IDENT_LO  = 32'h7c;
  localparam int unsigned IDX_IDENT_HI  = 32'h7d;
  localparam int unsigned IDX_VERSION   = 32'h7e;
  localparam int unsigned IDX_MASK_LO   = 32'h97;
  localparam int unsigned IDX_MASK_HI   = 32'h98;
  localparam int unsigned IDX_MASK_CTRL = 32'h99;
  localparam int unsigned IDX_RDBK_LO   = 32'h9a;
  localparam int unsigned IDX_RDBK_HI   = 32'h9b;
  localparam int unsigned IDX_LOF_LO    = 32'h9c;
  localparam int unsigned IDX_LOF_HI    = 32'h9d;
  localparam int unsigned IDX_PAT_LO    = 32'h9e;
  localparam int unsigned IDX_PAT_HI    = 32'h9f;
  localparam int unsigned IDX_CTRL      = 32'ha0;
  localparam int unsigned IDX_IRQ_STAT  = 32'ha1;
  localparam int unsigned IDX_IRQ_MASK  = 32'ha2;

  // ----------------------------------------------------------------
  // Field positions and sizes
  // ----------------------------------------------------------------
  localparam int unsigned MASK_WRITE_BIT  = 7;
  localparam int unsigned MASK_WORDS      = 12;
  localparam int unsigned CTRL_HOLD_BIT   = 0;
  localparam int unsigned CTRL_LOCK_BIT   = 1;
  localparam int unsigned BAD_RUN_LIMIT   = 4;
  localparam int unsigned VER_ADDR_BITS   = 6;
  localparam int unsigned IRQ_LOF_BIT     = 0;
  localparam int unsigned IRQ_PAT_BIT     = 1;

  // ----------------------------------------------------------------
  // Reset, saturation and identity values
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_MAX       = 16'hffff;
  // Identification value is arbitrary; only the top byte is meaningful
  localparam logic [15:0] DESIGN_IDENT    = 16'h5a00;

  typedef enum logic [1:0] {
    SYNC_HUNT,
    SYNC_LOCKED
  } sync_state_e;

  typedef struct packed {
    logic        pat_valid;
    logic        pat_good;
  } pattern_s;

endpackage

// File: version_rom.sv
module version_rom
(
  input  wire logic       i_core_clk,
  input  wire logic       i_ce,
  input  wire logic [5:0] i_addr,
  output logic      [7:0] o_char
);

  // ----------------------------------------------------------------
  // Board, config, version.revision, date, then DMA channels used/required
  // ----------------------------------------------------------------
  localparam string VERSION_TEXT = "gs4_ocx_ocx 3.12 02/14/2007 (4,4)";
  localparam int    TEXT_LEN     = 33;

  logic [7:0] rom_bytes [0:63];

  // Unused tail reads as NUL so software finds the end of the string
  generate
    for (genvar g = 0; g < 64; g++)
    begin : g_rom
      if (g < TEXT_LEN)
      begin : g_txt
        assign rom_bytes[g] = VERSION_TEXT[g];
      end
      else
      begin : g_nul
        assign rom_bytes[g] = 8'h00;
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk)
  begin
    if (i_ce)
    begin
      o_char <= rom_bytes[i_addr];
    end
  end

endmodule

// File: frame_stats_regs_properties.sv
module frame_stats_props
(
  input wire logic         i_core_clk,
  input wire logic         i_sys_rst,
  input wire logic         i_ce,
  input wire logic         i_psel,
  input wire logic         i_penable,
  input wire logic         i_pwrite,
  input wire logic [11:0]  i_paddr,
  input wire logic [31:0]  i_pwdata,
  input wire logic         o_pready,
  input wire logic [31:0]  o_prdata,
  input wire logic         o_pslverr,
  input wire logic         i_pat_valid,
  input wire logic         i_pat_good,
  input wire logic         o_frame_lock,
  input wire logic [191:0] o_demux_mask,
  input wire logic         o_irq
);
  // --------
  // Helpers
  // --------
  // Run of bad patterns since the last good one, saturating so it never wraps back to zero
  logic [2:0] run_r;
  logic       rst_q;
  wire        mask_wr = i_psel && i_penable && o_pready && i_pwrite
                        && i_paddr[11:2] == 10'h099 && i_pwdata[7];
  always_ff @(posedge i_core_clk)
    if (i_sys_rst)
      run_r <= 3'h0;
    else if (i_ce && i_pat_valid)
      run_r <= i_pat_good ? 3'h0 : run_r + {2'h0, run_r != 3'h7};
  // Outputs fall to reset values one edge late, so that edge is not judged
  always_ff @(posedge i_core_clk)
    rst_q <= i_sys_rst;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst || rst_q);
  // --------
  // Properties
  // --------
  setup_answer_a: assert property (i_psel && !i_penable && i_ce |=> o_pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  error_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("bad error response");
  unmapped_err_a: assert property (o_pready && i_paddr[11:2] < 10'h07c |-> o_pslverr)
    else $error("unmapped access not refused");
  upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  ident_value_a: assert property (o_pready && !i_pwrite && i_paddr[11:3] == 9'h03e
    |-> o_prdata[7:0] == (i_paddr[2] ? frame_stats_pkg::DESIGN_IDENT[15:8]
    : frame_stats_pkg::DESIGN_IDENT[7:0])) else $error("identity value wrong");
  lock_drop_a: assert property ($fell(o_frame_lock) |-> $past(run_r) >= 3'h4)
    else $error("lock lost before four bad patterns");
  lock_gain_a: assert property ($rose(o_frame_lock) |-> $past(run_r) == 3'h0)
    else $error("lock gained without good pattern");
  mask_change_a: assert property ($changed(o_demux_mask) |-> $past(mask_wr)
    || $past(mask_wr, 2)) else $error("mask changed without write");
  reset_clear_a: assert property (disable iff (1'b0) $fell(i_sys_rst) |->
    !o_frame_lock && !o_irq && o_demux_mask == '0) else $error("reset state wrong");
endmodule

// File: frame_stats_regs_tb.sv
module frame_stats_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Bench, model and tasks
  // --------
  logic         clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pv = 0, pg = 0;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0, prdata, q, seed = 32'h34;
  logic         pready, pslverr, lock, irq, e;
  logic [191:0] dmask;
  logic [15:0]  mv [12];
  logic [7:0]   a;
  int           errors = 0, n_checks = 0, cyc = 0, m_lock = 0, m_run = 0, m_lof = 0, m_pat = 0;
  int           m_hold = 0;
  string        ver = "gs4_ocx_ocx 3.12 02/14/2007 (4,4)";
  always #10 clk = ~clk;
  frame_stats_regs dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_pat_valid(pv),
    .i_pat_good(pg), .o_frame_lock(lock), .o_demux_mask(dmask), .o_irq(irq));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end
  // Extra edge at the end so the next request never lands in the release time step
  task automatic apb(input logic w, input int idx, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= 12'(idx * 4);
    pwdata <= {rnd() & 32'hffffff00} | d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    if (w && idx == 32'ha0) m_hold = d[0];
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd16(input int idx, input int x);
    logic [7:0] lo;
    apb(0, idx, 8'h00);
    lo = q[7:0];
    apb(0, idx + 1, 8'h00);
    chk({q[7:0], lo}, x);
  endtask
  // Model follows each pattern; held counters drop events instead of catching up later
  task automatic pat(input logic g);
    pv <= 1;
    pg <= g;
    @(posedge clk);
    pv <= 0;
    if (!m_lock) m_lock = g;
    else if (g) m_run = 0;
    else
    begin
      m_run++;
      if (!m_hold) m_pat = m_pat < 65535 ? m_pat + 1 : m_pat;
      if (m_run == 4)
      begin
        m_lock = 0;
        m_run = 0;
        if (!m_hold) m_lof = m_lof < 65535 ? m_lof + 1 : m_lof;
      end
    end
    repeat (3) @(posedge clk);
    chk(lock, m_lock);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd16(32'h9c, 0);
    rd16(32'h9e, 0);
    rd16(32'h7c, frame_stats_pkg::DESIGN_IDENT);
    apb(1, 32'h9c, 8'h55);
    rd16(32'h9c, 0);
    apb(0, 32'h10, 8'h00);
    chk(e, 1);
    chk(q, 0);
    repeat (20)
    begin
      q = rnd();
      a = q[7:0];
      apb(1, 32'h7e, a);
      apb(0, 32'h7e, 8'h00);
      chk(q[7:0], a[5:0] < ver.len() ? ver[a[5:0]] : 8'h00);
    end
    foreach (mv[w])
    begin
      q = rnd();
      mv[w] = q[15:0];
      apb(1, 32'h97, mv[w][7:0]);
      apb(1, 32'h98, mv[w][15:8]);
      apb(1, 32'h99, 8'h80 | 8'(w));
    end
    foreach (mv[w])
    begin
      apb(1, 32'h99, 8'(w));
      rd16(32'h9a, mv[w]);
      chk(dmask[191 - 16 * w -: 16], mv[w]);
    end
    pat(1);
    pat(0);
    pat(1);
    rd16(32'h9e, m_pat);
    rd16(32'h9c, m_lof);
    apb(1, 32'ha1, 8'h03);
    apb(1, 32'ha2, 8'h01);
    chk(irq, 0);
    repeat (4) pat(0);
    rd16(32'h9c, m_lof);
    chk(irq, 1);
    apb(0, 32'ha1, 8'h00);
    chk(q, 32'h3);
    apb(1, 32'ha2, 8'h00);
    @(posedge clk);
    chk(irq, 0);
    apb(1, 32'ha2, 8'h01);
    @(posedge clk);
    chk(irq, 1);
    apb(1, 32'ha1, 8'h01);
    @(posedge clk);
    chk(irq, 0);
    pat(1);
    apb(1, 32'ha0, 8'h01);
    apb(0, 32'ha0, 8'h00);
    chk(q, 32'h3);
    repeat (5) pat(0);
    rd16(32'h9c, m_lof);
    rd16(32'h9e, m_pat);
    apb(1, 32'ha0, 8'h00);
    ce <= 0;
    pv <= 1;
    pg <= 1;
    @(posedge clk);
    pv <= 0;
    ce <= 1;
    repeat (2) @(posedge clk);
    chk(lock, m_lock);
    repeat (150)
    begin
      q = rnd();
      pat(q[0]);
    end
    rd16(32'h9c, m_lof);
    rd16(32'h9e, m_pat);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    m_lock = 0;
    m_lof = 0;
    m_pat = 0;
    m_run = 0;
    m_hold = 0;
    @(posedge clk);
    chk(lock, 0);
    chk(dmask[191:160] | dmask[31:0], 0);
    rd16(32'h9c, 0);
    rd16(32'h9e, 0);
    conclude();
  end
endmodule
bind frame_stats_regs frame_stats_props props_u (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_pat_valid(i_pat_valid), .i_pat_good(i_pat_good), .o_frame_lock(o_frame_lock),
  .o_demux_mask(o_demux_mask), .o_irq(o_irq));
